//--- cscr_map.vh
`ifndef CSCR_MAP_VH
`define CSCR_MAP_VH
// register indices (byte address = 4 * index)
`define CSCR_IDX_OSC_CTRL2      8'he2
`define CSCR_IDX_MAIN_TRIM      8'he8
`define CSCR_IDX_LOW_TRIM       8'he9
`define CSCR_IDX_CUR_TRIM       8'hef
`define CSCR_IDX_SYS_STAT1      8'hfe
// system_status_control_one fields
`define CSCR_BIT_REBOOT_REPEAT  7
`define CSCR_BIT_SLOW_MAIN      4
`define CSCR_BIT_FLAG_WRITTEN   3
`define CSCR_BIT_CRYSTAL_FLAG   2
`define CSCR_BIT_RAM_INIT_DIS   0
// oscillator_control_two fields
`define CSCR_BIT_PLL_LOW_GAIN   7
`define CSCR_BIT_SLEEP_EXTEND   4
`define CSCR_BIT_TIMER_SRC      3
`define CSCR_BIT_EXT_CLK_EN     2
`define CSCR_BIT_RSVD           1
`define CSCR_BIT_DOUBLER_DIS    0
// writable masks
`define CSCR_MASK_OSC_CTRL2     8'h9d
`define CSCR_MASK_CUR_TRIM      8'h03
`define CSCR_MASK_LOW_TRIM      8'h3f
// reset values
`define CSCR_RST_OSC_CTRL2      8'h00
`define CSCR_RST_MAIN_TRIM      8'h00
`define CSCR_RST_LOW_TRIM       8'h00
`define CSCR_RST_CUR_TRIM       8'h00
// AXI responses
`define CSCR_RESP_OKAY          2'b00
`define CSCR_RESP_SLVERR        2'b10
`endif

//--- cscr_clock_source_regs.v
`timescale 1ns/1ps
`include "cscr_map.vh"

// What this block does
// - flag-written status bit reads one after write
// - rstn clears flag-written status bit, watchdog reset does not
// - crystal flag accepts one write per rstn reset
// - flag zero blocks switch to crystal
// - flag one lets firmware switch once the crystal is settled
// - status bit shows boot ran more once
// - ram-init-disable zero: watchdog clears maximum SRAM
// - ram-init-disable one: watchdog clears minimum SRAM
// - slow select drops main oscillator to low
// - system clock follows main oscillator unless external
// - pll gain bit set means low gain
// - sleep-extend bit enables long sleep intervals
// - timer source picks crystal or low-speed oscillator
// - external enable makes external clock the source
// - doubler-disable bit stops double-rate clock
// - larger main trim raises oscillator frequency
// - boot loads factory high-supply trim value
// - current trim: 00 largest, 11 smallest current
// - bias trim inverts upper bit internally
// - frequency trim inverts its top bit internally
module cscr_clock_source_regs #(
    parameter [7:0] FACTORY_MAIN_TRIM = 8'h80,
    parameter [7:0] FACTORY_LOW_TRIM  = 8'h00
) (
    input  wire        core_clk,
    input  wire        rstn,
    // AXI4-Lite slave
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // boot sequencer and reset sources
    input  wire        bootLoadTrim,
    input  wire        bootRoutineRun,
    input  wire        watchdogReset,
    input  wire        crystalSettled,
    input  wire        crystalRequest,
    // controls to oscillators and clock tree
    output reg         slowMainOscSelect,
    output reg         pllLowGain,
    output reg         sleepIntervalExtend,
    output reg         timerSourceSelect,
    output reg         externalClockEnable,
    output reg         doublerDisable,
    output reg  [7:0]  mainOscTrim,
    output reg  [1:0]  currentTuneField,
    output reg  [1:0]  lowBiasTrim,
    output reg  [3:0]  lowFreqTrim,
    output reg         lowSpeedUsesCrystal,
    output reg         timerClockUsesCrystal,
    output reg         systemClockFromMain,
    output reg         sramInitMaximum,
    output reg         sramInitMinimum,
    output reg         sramInitStart
);

    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_WRITE = 3'b010;
    localparam [2:0] ST_RESP  = 3'b100;

    reg  [2:0]  wrState;
    reg  [9:0]  wrIndex;
    reg  [7:0]  wrData;
    reg         wrLaneOk;
    reg         haveAddr;
    reg         haveData;
    reg  [7:0]  oscCtrl2;
    reg  [7:0]  lowTrimRaw;
    reg         crystalPresentFlag;
    reg         crystalFlagWritten;
    reg         rebootRepeatStatus;
    reg         bootSeen;
    reg         ramInitDisable;
    reg  [2:0]  wdSync;
    reg  [2:0]  bootSync;
    reg  [7:0]  sysStat1;
    reg  [7:0]  readByte;
    reg         readHit;
    wire [9:0]  rdIndex;
    reg         wdLevel;
    reg         bootLevel;
    reg         next_crystalPresentFlag;
    reg         next_crystalFlagWritten;
    wire        wdAgree;
    wire        bootAgree;
    wire        wdRise;
    wire        bootRise;
    wire        wrCommit;
    wire        statusWrite;

    assign rdIndex   = s_axi_araddr[11:2];
    // a level change counts only once the second and third stages agree
    assign wdAgree   = ~(wdSync[2] ^ wdSync[1]);
    assign bootAgree = ~(bootSync[2] ^ bootSync[1]);
    // one-cycle rise of the filtered level; idle level is low, so no edge after reset
    assign wdRise    = wdAgree & wdSync[2] & ~wdLevel;
    assign bootRise  = bootAgree & bootSync[2] & ~bootLevel;
    // a write lands in the cycle after both halves are taken
    assign wrCommit    = (wrState == ST_WRITE) && wrLaneOk;
    assign statusWrite = wrCommit &&
                         (wrIndex == {2'b00, `CSCR_IDX_SYS_STAT1});

    // status register image
    always @* begin
        sysStat1 = 8'h00;
        sysStat1[`CSCR_BIT_REBOOT_REPEAT] = rebootRepeatStatus;
        sysStat1[`CSCR_BIT_SLOW_MAIN]     = slowMainOscSelect;
        sysStat1[`CSCR_BIT_FLAG_WRITTEN]  = crystalFlagWritten;
        sysStat1[`CSCR_BIT_CRYSTAL_FLAG]  = crystalPresentFlag;
        sysStat1[`CSCR_BIT_RAM_INIT_DIS]  = ramInitDisable;
    end

    // read decode
    always @* begin
        readByte = 8'h00;
        readHit  = 1'b1;
        case (rdIndex)
            {2'b00, `CSCR_IDX_OSC_CTRL2}: readByte = oscCtrl2;
            {2'b00, `CSCR_IDX_MAIN_TRIM}: readByte = mainOscTrim;
            {2'b00, `CSCR_IDX_LOW_TRIM}:  readByte = lowTrimRaw;
            {2'b00, `CSCR_IDX_CUR_TRIM}:  readByte = {6'h00, currentTuneField};
            {2'b00, `CSCR_IDX_SYS_STAT1}: readByte = sysStat1;
            default:                      readHit  = 1'b0;
        endcase
    end

    // input synchronisers for pin-level events
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wdSync    <= 3'b000;
            bootSync  <= 3'b000;
            wdLevel   <= 1'b0;
            bootLevel <= 1'b0;
        end else begin
            wdSync    <= {wdSync[1:0], watchdogReset};
            bootSync  <= {bootSync[1:0], bootRoutineRun};
            // filtered levels follow only agreeing stages, a glitch is dropped
            wdLevel   <= wdAgree ? wdSync[2] : wdLevel;
            bootLevel <= bootAgree ? bootSync[2] : bootLevel;
        end
    end

    // write channel: address and data in either order, then response
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wrState       <= ST_IDLE;
            wrIndex       <= 10'h000;
            wrData        <= 8'h00;
            wrLaneOk      <= 1'b0;
            haveAddr      <= 1'b0;
            haveData      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CSCR_RESP_OKAY;
        end else begin
            case (wrState)
                ST_IDLE: begin
                    s_axi_awready <= ~haveAddr & ~(s_axi_awvalid & s_axi_awready);
                    s_axi_wready  <= ~haveData & ~(s_axi_wvalid & s_axi_wready);
                    if (s_axi_awvalid && s_axi_awready) begin
                        wrIndex  <= s_axi_awaddr[11:2];
                        haveAddr <= 1'b1;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        wrData   <= s_axi_wdata[7:0];
                        wrLaneOk <= s_axi_wstrb[0];
                        haveData <= 1'b1;
                    end
                    if ((haveAddr || (s_axi_awvalid && s_axi_awready)) &&
                        (haveData || (s_axi_wvalid && s_axi_wready))) begin
                        s_axi_awready <= 1'b0;
                        s_axi_wready  <= 1'b0;
                        wrState       <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    haveAddr     <= 1'b0;
                    haveData     <= 1'b0;
                    s_axi_bvalid <= 1'b1;
                    s_axi_bresp  <= wrHit(wrIndex) ? `CSCR_RESP_OKAY : `CSCR_RESP_SLVERR;
                    wrState      <= ST_RESP;
                end
                ST_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wrState      <= ST_IDLE;
                    end
                end
                default: wrState <= ST_IDLE;
            endcase
        end
    end

    // mapped-address check for writes
    function wrHit;
        input [9:0] idx;
        begin
            wrHit = (idx == {2'b00, `CSCR_IDX_OSC_CTRL2}) ||
                    (idx == {2'b00, `CSCR_IDX_MAIN_TRIM}) ||
                    (idx == {2'b00, `CSCR_IDX_LOW_TRIM})  ||
                    (idx == {2'b00, `CSCR_IDX_CUR_TRIM})  ||
                    (idx == {2'b00, `CSCR_IDX_SYS_STAT1});
        end
    endfunction

    // register file updates; boot trim load wins over a software write
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            oscCtrl2           <= `CSCR_RST_OSC_CTRL2;
            mainOscTrim        <= `CSCR_RST_MAIN_TRIM;
            lowTrimRaw         <= `CSCR_RST_LOW_TRIM;
            currentTuneField   <= 2'b00;
            slowMainOscSelect  <= 1'b0;
            ramInitDisable     <= 1'b0;
        end else begin
            if (wrCommit) begin
                case (wrIndex)
                    {2'b00, `CSCR_IDX_OSC_CTRL2}:
                        oscCtrl2 <= wrData & `CSCR_MASK_OSC_CTRL2;
                    {2'b00, `CSCR_IDX_MAIN_TRIM}:
                        mainOscTrim <= wrData;
                    {2'b00, `CSCR_IDX_LOW_TRIM}:
                        lowTrimRaw <= wrData & `CSCR_MASK_LOW_TRIM;
                    {2'b00, `CSCR_IDX_CUR_TRIM}:
                        currentTuneField <= wrData[1:0];
                    {2'b00, `CSCR_IDX_SYS_STAT1}: begin
                        // slow select and ram-init-disable stay writable
                        slowMainOscSelect <= wrData[`CSCR_BIT_SLOW_MAIN];
                        ramInitDisable    <= wrData[`CSCR_BIT_RAM_INIT_DIS];
                    end
                    default: ;
                endcase
            end
            if (bootLoadTrim) begin
                mainOscTrim <= FACTORY_MAIN_TRIM;
                lowTrimRaw  <= FACTORY_LOW_TRIM & `CSCR_MASK_LOW_TRIM;
            end
        end
    end

    // crystal flag takes the first status write after reset, then locks
    always @* begin
        next_crystalPresentFlag = crystalPresentFlag;
        next_crystalFlagWritten = crystalFlagWritten;
        if (statusWrite && !crystalFlagWritten) begin
            next_crystalPresentFlag = wrData[`CSCR_BIT_CRYSTAL_FLAG];
            next_crystalFlagWritten = 1'b1;
        end
    end

    // lock state, cleared by rstn but not by a watchdog reset
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            crystalPresentFlag <= 1'b0;
            crystalFlagWritten <= 1'b0;
        end else begin
            crystalPresentFlag <= next_crystalPresentFlag;
            crystalFlagWritten <= next_crystalFlagWritten;
        end
    end

    // boot routine counting: second run sets the repeat status
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bootSeen           <= 1'b0;
            rebootRepeatStatus <= 1'b0;
        end else if (bootRise) begin
            bootSeen <= 1'b1;
            if (bootSeen) begin
                rebootRepeatStatus <= 1'b1;
            end
        end
    end

    // read channel, answer one cycle after address taken
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `CSCR_RESP_OKAY;
        end else begin
            if (s_axi_rvalid) begin
                if (s_axi_rready) begin
                    s_axi_rvalid <= 1'b0;
                end
                s_axi_arready <= 1'b0;
            end else if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h000000, readByte};
                s_axi_rresp   <= readHit ? `CSCR_RESP_OKAY : `CSCR_RESP_SLVERR;
            end else begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // oscillator and clock-tree controls, one cycle behind the register
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pllLowGain          <= 1'b0;
            sleepIntervalExtend <= 1'b0;
            timerSourceSelect   <= 1'b0;
            externalClockEnable <= 1'b0;
            doublerDisable      <= 1'b0;
            systemClockFromMain <= 1'b1;
        end else begin
            pllLowGain          <= oscCtrl2[`CSCR_BIT_PLL_LOW_GAIN];
            sleepIntervalExtend <= oscCtrl2[`CSCR_BIT_SLEEP_EXTEND];
            timerSourceSelect   <= oscCtrl2[`CSCR_BIT_TIMER_SRC];
            externalClockEnable <= oscCtrl2[`CSCR_BIT_EXT_CLK_EN];
            doublerDisable      <= oscCtrl2[`CSCR_BIT_DOUBLER_DIS];
            systemClockFromMain <= ~oscCtrl2[`CSCR_BIT_EXT_CLK_EN];
        end
    end

    // low-speed trim fields leave with their top bits inverted
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lowBiasTrim <= 2'b00;
            lowFreqTrim <= 4'h0;
        end else begin
            lowBiasTrim <= {~lowTrimRaw[5], lowTrimRaw[4]};
            lowFreqTrim <= {~lowTrimRaw[3], lowTrimRaw[2:0]};
        end
    end

    // crystal use only with the flag set and the crystal settled
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lowSpeedUsesCrystal   <= 1'b0;
            timerClockUsesCrystal <= 1'b0;
        end else begin
            lowSpeedUsesCrystal   <= crystalPresentFlag & crystalRequest &
                                     crystalSettled;
            timerClockUsesCrystal <= crystalPresentFlag & crystalSettled &
                                     oscCtrl2[`CSCR_BIT_TIMER_SRC];
        end
    end

    // sram clear amount, start pulse on a filtered watchdog edge
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sramInitMaximum <= 1'b1;
            sramInitMinimum <= 1'b0;
            sramInitStart   <= 1'b0;
        end else begin
            sramInitMaximum <= ~ramInitDisable;
            sramInitMinimum <= ramInitDisable;
            sramInitStart   <= wdRise;
        end
    end

endmodule // cscr_clock_source_regs

//--- cscr_regs_asserts.sv
`timescale 1ns/1ps
// watches the register block from its ports
module cscr_regs_asserts (
    input wire        core_clk,
    input wire        rstn,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire        crystalRequest,
    input wire        crystalSettled,
    input wire        externalClockEnable,
    input wire        systemClockFromMain,
    input wire        sramInitMaximum,
    input wire        sramInitMinimum,
    input wire        sramInitStart,
    input wire        lowSpeedUsesCrystal,
    input wire        timerClockUsesCrystal
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // answers stand until taken, read answer one cycle after address, no write taken while answering
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    read_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    ready_low_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken while answering");
    // clock and sram selections
    clock_source_a: assert property ($stable(externalClockEnable) |-> systemClockFromMain != externalClockEnable)
        else $error("system clock source wrong");
    sram_amount_a: assert property (sramInitMaximum != sramInitMinimum)
        else $error("sram amount select wrong");
    sram_pulse_a: assert property (sramInitStart |=> !sramInitStart)
        else $error("sram start longer than one cycle");
    crystal_gate_a: assert property (lowSpeedUsesCrystal |-> $past(crystalRequest) && $past(crystalSettled))
        else $error("crystal used without request");
    timer_gate_a: assert property (timerClockUsesCrystal |-> $past(crystalSettled))
        else $error("timer on unsettled crystal");
endmodule // cscr_regs_asserts

bind cscr_clock_source_regs cscr_regs_asserts i_chk (.core_clk, .rstn, .s_axi_awready,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .crystalRequest, .crystalSettled,
    .externalClockEnable, .systemClockFromMain, .sramInitMaximum, .sramInitMinimum,
    .sramInitStart, .lowSpeedUsesCrystal, .timerClockUsesCrystal);

//--- clock_source_control_regs_test.sv
`timescale 1ns/1ps
`include "cscr_map.vh"
module clock_source_control_regs_test;
    localparam [7:0]  MAIN_F = 8'h5a;
    localparam [7:0]  LOW_F  = 8'h21;
    localparam [1:0]  OK     = `CSCR_RESP_OKAY;
    localparam [1:0]  ERR    = `CSCR_RESP_SLVERR;
    localparam [11:0] A_OSC  = {2'b00, `CSCR_IDX_OSC_CTRL2, 2'b00};
    localparam [11:0] A_MAIN = {2'b00, `CSCR_IDX_MAIN_TRIM, 2'b00};
    localparam [11:0] A_LOW  = {2'b00, `CSCR_IDX_LOW_TRIM, 2'b00};
    localparam [11:0] A_CUR  = {2'b00, `CSCR_IDX_CUR_TRIM, 2'b00};
    localparam [11:0] A_STAT = {2'b00, `CSCR_IDX_SYS_STAT1, 2'b00};
    logic        core_clk = 0, rstn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, bootLoadTrim = 0, bootRoutineRun = 0;
    logic        watchdogReset = 0, crystalSettled = 0, crystalRequest = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0]  s_axi_wstrb = 0;
    logic [7:0]  d;
    integer      i, checks = 0, miscompares = 0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp, currentTuneField, lowBiasTrim;
    wire  [31:0] s_axi_rdata;
    wire  [7:0]  mainOscTrim;
    wire  [3:0]  lowFreqTrim;
    wire         slowMainOscSelect, pllLowGain, sleepIntervalExtend, timerSourceSelect;
    wire         externalClockEnable, doublerDisable, lowSpeedUsesCrystal, timerClockUsesCrystal;
    wire         systemClockFromMain, sramInitMaximum, sramInitMinimum, sramInitStart;

    cscr_clock_source_regs #(.FACTORY_MAIN_TRIM(MAIN_F), .FACTORY_LOW_TRIM(LOW_F)) i_dut (
        .core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .bootLoadTrim, .bootRoutineRun, .watchdogReset, .crystalSettled,
        .crystalRequest, .slowMainOscSelect, .pllLowGain, .sleepIntervalExtend, .timerSourceSelect,
        .externalClockEnable, .doublerDisable, .mainOscTrim, .currentTuneField, .lowBiasTrim,
        .lowFreqTrim, .lowSpeedUsesCrystal, .timerClockUsesCrystal, .systemClockFromMain,
        .sramInitMaximum, .sramInitMinimum, .sramInitStart);

    // free-running core clock
    always #12.5 core_clk = ~core_clk;

    task end_of_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input [31:0] got, input [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task tmo;
        miscompares = miscompares + 1;
        end_of_test;
    endtask

    task rst;
        rstn <= 1'b0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
    endtask

    // write one byte, upper lanes carry noise
    task automatic wr(input [11:0] a, input [7:0] v, input [3:0] s, input [1:0] er);
        integer n;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'($urandom), v};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) begin
                s_axi_bready <= 1'b0;
                chk(32'(s_axi_bresp), 32'(er));
                n = 99;
            end
        end
        if (n == 40) tmo;
    endtask

    // read one register, check its response and, when OK is expected, its whole data word, upper bytes expected zero
    task automatic rd(input [11:0] a, input [7:0] exp, input [1:0] er);
        integer n;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) begin
                s_axi_rready <= 1'b0;
                chk(32'(s_axi_rresp), 32'(er));
                if (er == OK) chk(s_axi_rdata, {24'h0, exp});
                n = 99;
            end
        end
        if (n == 40) tmo;
    endtask

    // main sequence
    initial begin
        i = $urandom(79);
        rst;
        rd(A_OSC, `CSCR_RST_OSC_CTRL2, OK);
        rd(A_MAIN, `CSCR_RST_MAIN_TRIM, OK);
        rd(A_LOW, `CSCR_RST_LOW_TRIM, OK);
        rd(A_CUR, `CSCR_RST_CUR_TRIM, OK);
        rd(A_STAT, 8'h00, OK);
        wr(12'h004, 8'hff, 4'h1, ERR);
        rd(12'h004, 8'h00, ERR);
        for (i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'hff : 8'($urandom);
            wr(A_OSC, d & 8'hfd, 4'h1, OK);
            wr(A_OSC, ~d & 8'hfd, 4'h0, OK);
            wr(A_MAIN, d, 4'h1, OK);
            wr(A_LOW, d, 4'h1, OK);
            wr(A_CUR, d, 4'h1, OK);
            rd(A_OSC, d & `CSCR_MASK_OSC_CTRL2, OK);
            rd(A_MAIN, d, OK);
            rd(A_LOW, d & 8'h3f, OK);
            rd(A_CUR, d & 8'h03, OK);
            chk(32'({pllLowGain, sleepIntervalExtend, timerSourceSelect}), 32'({d[7], d[4:3]}));
            chk(32'({externalClockEnable, systemClockFromMain, doublerDisable}), 32'({d[2], ~d[2], d[0]}));
            chk(32'(mainOscTrim), 32'(d));
            chk(32'({lowBiasTrim, lowFreqTrim}), 32'({~d[5], d[4], ~d[3], d[2:0]}));
            chk(32'(currentTuneField), 32'(d[1:0]));
        end
        crystalSettled <= 1'b1;
        crystalRequest <= 1'b1;
        wr(A_OSC, 8'h08, 4'h1, OK);
        wr(A_STAT, 8'h11, 4'h1, OK);
        wr(A_STAT, 8'h04, 4'h1, OK);
        rd(A_STAT, 8'h08, OK);
        chk(32'({lowSpeedUsesCrystal, timerClockUsesCrystal}), 32'h0);
        rst;
        rd(A_STAT, 8'h00, OK);
        wr(A_STAT, 8'h11, 4'h1, OK);
        rd(A_STAT, 8'h19, OK);
        chk(32'({slowMainOscSelect, sramInitMinimum, sramInitMaximum}), 32'h6);
        rst;
        wr(A_OSC, 8'h08, 4'h1, OK);
        wr(A_STAT, 8'h04, 4'h1, OK);
        rd(A_STAT, 8'h0c, OK);
        chk(32'({lowSpeedUsesCrystal, timerClockUsesCrystal}), 32'h3);
        crystalRequest <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(32'({lowSpeedUsesCrystal, timerClockUsesCrystal}), 32'h1);
        watchdogReset <= 1'b1;
        for (i = 0; i < 20 && sramInitStart !== 1'b1; i++) @(posedge core_clk);
        if (i == 20) tmo;
        chk(32'(sramInitMaximum), 32'h1);
        watchdogReset <= 1'b0;
        for (i = 0; i < 2; i++) begin
            bootRoutineRun <= 1'b1;
            repeat (5) @(posedge core_clk);
            bootRoutineRun <= 1'b0;
            repeat (5) @(posedge core_clk);
            rd(A_STAT, (i == 1) ? 8'h8c : 8'h0c, OK);
        end
        bootLoadTrim <= 1'b1;
        @(posedge core_clk);
        bootLoadTrim <= 1'b0;
        rd(A_MAIN, MAIN_F, OK);
        rd(A_LOW, LOW_F & 8'h3f, OK);
        end_of_test;
    end
endmodule // clock_source_control_regs_test
